// ---- rtl/fcpwm_pkg.sv ----
// Summary of operation
// R1: A 16-bit up counter clears at the period boundary and raises a request.
// R2: The period register sets the counting cycle and waveform resolution.
// R3: Four channels share GPIO pins; each select bit swaps in the waveform.
// R4: A cleared select bit hands the pin back to its last GPIO state.
// R5: A timer event wakes the system from idle when the interrupt is enabled.
// R6: Overflow sets the overflow flag at once; software reads and writes it.
// R7: The timer clock is the oscillator divided by 1 to 128, three-bit field.
// R8: Divider codes 000 to 111 give divide by 128, 64, 32, 16, 8, 4, 2, 1.
// R9: The request reaches the processor only with the interrupt enable set.
// R10: With enable set, a channel switches to waveform after synchronisation.
// R11: Clearing enable returns all channels to their last GPIO states.
// R12: The output is high when the counter starts from zero.
// R13: The output goes low when the counter equals the duty value.
// R14: Overflow ends the cycle, reloads zero and drives high for the next.
// R15: Software never programs a duty value above the period value.
// R16: One-pulse clear runs continuously; set gives one pulse and the flag.
// R17: After one pulse enable clears itself; software sets it for another.
// R18: Each pair inverts its waveform when its invert bit is one.
// R19: Dead band lies inside the high pulse, from short and duty minus long.
// R20: A dead band longer than the duty time gives no output pulse.
// R21: Zero period at enable stops the waveform and locks period updates.
// R22: Dead band is split between leading and trailing edge of the pulse.
package fcpwm_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_CHAN    = 5'h04;
  localparam logic [4:0] OFS_PERIOD  = 5'h08;
  localparam logic [4:0] OFS_DUTY    = 5'h0c;
  localparam logic [4:0] OFS_DBLONG  = 5'h10;
  localparam logic [4:0] OFS_DBSHORT = 5'h14;
  localparam logic [4:0] OFS_IRQ     = 5'h18;
  localparam logic [4:0] OFS_COUNT   = 5'h1c;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_DIV_LO    = 4;
  localparam int BIT_INV2      = 3;
  localparam int BIT_INV1      = 2;
  localparam int BIT_ONE_PULSE = 0;
  localparam int BIT_CH0       = 0;
  localparam int BIT_CH1       = 1;
  localparam int BIT_CH2       = 4;
  localparam int BIT_CH3       = 5;
  localparam int BIT_IRQ_EN    = 7;
  localparam int BIT_FLAG      = 3;
  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [2:0]  RST_DIV    = 3'h0;
  localparam logic [6:0]  DIV_MASK   = 7'h7f;
  localparam int          NUM_CH     = 4;
endpackage

// ---- rtl/fcpwm_top.sv ----
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module fcpwm_top
  import fcpwm_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // GPIO side of the shared pins
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  // Pins
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe,
  // Processor side
  output logic             irq,
  output logic             wake
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        ack_r;
  logic [31:0] readdata_r;
  logic        enable_r;
  logic        enable_d_r;
  logic [2:0]  div_sel_r;
  logic [1:0]  inv_r;
  logic        one_pulse_r;
  logic [3:0]  chan_sel_r;
  logic [15:0] period_r;
  logic [15:0] duty_r;
  logic [15:0] db_long_r;
  logic [7:0]  db_short_r;
  logic        irq_en_r;
  logic        flag_r;
  logic [15:0] count_r;
  logic [6:0]  pre_r;
  logic        synced_r;
  logic        stopped_r;
  logic [3:0]  pin_out_r;
  logic [3:0]  pin_oe_r;

  logic        wr_acc;
  logic        tick;
  logic [6:0]  div_mask;
  logic        running;
  logic        wrap;
  logic        ovf_evt;
  logic [15:0] trail_end;
  logic        wave;
  logic [3:0]  live;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [15:0] res;
    res = old_v;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake: answer one cycle after the request
  // ---------------------------------------------------------------
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_acc      = write & ack_r;
  assign readdata    = readdata_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata_r <= 32'h00000000;
    end else if (read & ~ack_r) begin
      readdata_r <= 32'h00000000;
      case (address)
        OFS_CTRL: begin
          readdata_r[BIT_ENABLE]                <= enable_r;
          readdata_r[BIT_DIV_LO +: 3]           <= div_sel_r;
          readdata_r[BIT_INV2]                  <= inv_r[1];
          readdata_r[BIT_INV1]                  <= inv_r[0];
          readdata_r[BIT_ONE_PULSE]             <= one_pulse_r;
        end
        OFS_CHAN: begin
          readdata_r[BIT_CH0] <= chan_sel_r[0];
          readdata_r[BIT_CH1] <= chan_sel_r[1];
          readdata_r[BIT_CH2] <= chan_sel_r[2];
          readdata_r[BIT_CH3] <= chan_sel_r[3];
        end
        OFS_PERIOD:  readdata_r[15:0] <= period_r;
        OFS_DUTY:    readdata_r[15:0] <= duty_r;
        OFS_DBLONG:  readdata_r[15:0] <= db_long_r;
        OFS_DBSHORT: readdata_r[7:0]  <= db_short_r;
        OFS_IRQ: begin
          readdata_r[BIT_IRQ_EN] <= irq_en_r;
          readdata_r[BIT_FLAG]   <= flag_r;
        end
        OFS_COUNT:   readdata_r[15:0] <= count_r;
        default:     readdata_r <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_r    <= 1'b0;
      div_sel_r   <= RST_DIV;
      inv_r       <= 2'h0;
      one_pulse_r <= 1'b0;
    end else if (wr_acc && address == OFS_CTRL && byteenable[0]) begin
      enable_r    <= writedata[BIT_ENABLE];
      div_sel_r   <= writedata[BIT_DIV_LO +: 3];
      inv_r       <= {writedata[BIT_INV2], writedata[BIT_INV1]};
      one_pulse_r <= writedata[BIT_ONE_PULSE];
    end else if (ovf_evt && one_pulse_r) begin
      enable_r <= 1'b0;  // [R17]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chan_sel_r <= 4'h0;
    end else if (wr_acc && address == OFS_CHAN && byteenable[0]) begin
      chan_sel_r <= {writedata[BIT_CH3], writedata[BIT_CH2],
                     writedata[BIT_CH1], writedata[BIT_CH0]};  // [R3]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      period_r <= RST_WORD16;
    end else if (wr_acc && address == OFS_PERIOD && !stopped_r) begin
      period_r <= merge16(period_r, writedata, byteenable);  // [R2] [R21]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      duty_r     <= RST_WORD16;
      db_long_r  <= RST_WORD16;
      db_short_r <= RST_BYTE;
    end else if (wr_acc) begin
      if (address == OFS_DUTY) begin
        duty_r <= merge16(duty_r, writedata, byteenable);
      end
      if (address == OFS_DBLONG) begin
        db_long_r <= merge16(db_long_r, writedata, byteenable);
      end
      if (address == OFS_DBSHORT && byteenable[0]) begin
        db_short_r <= writedata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt enable and overflow flag
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_en_r <= 1'b0;
      flag_r   <= 1'b0;
    end else begin
      if (wr_acc && address == OFS_IRQ && byteenable[0]) begin
        irq_en_r <= writedata[BIT_IRQ_EN];
        flag_r   <= writedata[BIT_FLAG] | ovf_evt;  // [R6]
      end else if (ovf_evt) begin
        flag_r <= 1'b1;  // [R1] [R6] [R16]
      end
    end
  end

  assign irq  = flag_r & irq_en_r;  // [R9]
  assign wake = flag_r & irq_en_r;  // [R5]

  // ---------------------------------------------------------------
  // Clock divider
  // ---------------------------------------------------------------
  assign div_mask = DIV_MASK >> div_sel_r;          // [R7] [R8]
  assign tick     = (pre_r & div_mask) == div_mask;

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_r <= 7'h00;
    end else begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // Start synchronisation and zero-period lock
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_d_r <= 1'b0;
      stopped_r  <= 1'b0;
      synced_r   <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
      if (!enable_r) begin
        stopped_r <= 1'b0;
        synced_r  <= 1'b0;
      end else begin
        if (!enable_d_r && period_r == RST_WORD16) begin
          stopped_r <= 1'b1;  // [R21]
        end
        if (!synced_r && tick && !stopped_r && enable_d_r) begin
          synced_r <= 1'b1;  // [R10]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Cycle counter
  // ---------------------------------------------------------------
  assign running = enable_r & synced_r & ~stopped_r;
  assign wrap    = count_r == period_r - 16'h0001;
  assign ovf_evt = running & tick & wrap;

  always_ff @(posedge clock) begin
    if (rst) begin
      count_r <= RST_WORD16;
    end else if (!running) begin
      count_r <= RST_WORD16;
    end else if (tick) begin
      if (wrap) begin
        count_r <= RST_WORD16;  // [R1] [R14]
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Waveform with dead band
  // ---------------------------------------------------------------
  assign trail_end = duty_r - db_long_r;  // [R19] [R22]
  assign wave = (db_long_r <= duty_r)                          // [R20]
              && (count_r >= {8'h00, db_short_r})               // [R12] [R19]
              && (count_r < trail_end);                          // [R13]

  // ---------------------------------------------------------------
  // Pin multiplexing per channel
  // ---------------------------------------------------------------
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    assign live[k] = running & chan_sel_r[k];

    always_ff @(posedge clock) begin
      if (rst) begin
        pin_out_r[k] <= 1'b0;
        pin_oe_r[k]  <= 1'b0;
      end else if (live[k]) begin
        pin_out_r[k] <= wave ^ inv_r[k/2];  // [R3] [R18]
        pin_oe_r[k]  <= 1'b1;
      end else begin
        pin_out_r[k] <= gpio_out[k];        // [R4] [R11]
        pin_oe_r[k]  <= gpio_oe[k];
      end
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_wrap_zero: assert property (@(posedge clock) disable iff (rst)  // [R14]
    ovf_evt |=> count_r == 16'h0000)
    else $error("counter did not reload zero at overflow");

  chk_flag_set: assert property (@(posedge clock) disable iff (rst)  // [R6]
    ovf_evt |=> flag_r)
    else $error("overflow flag not set");

  chk_irq_gate: assert property (@(posedge clock) disable iff (rst)  // [R9]
    (ovf_evt && !wr_acc) |=> irq == $past(irq_en_r) && wake == irq)
    else $error("interrupt not gated by its enable");

  chk_sync_first: assert property (@(posedge clock) disable iff (rst)  // [R10]
    (enable_r && !enable_d_r) |-> !running ##1 !running)
    else $error("waveform before synchronisation");

  chk_one_pulse: assert property (@(posedge clock) disable iff (rst)  // [R17]
    (ovf_evt && one_pulse_r && !wr_acc) |=> !enable_r ##1 pin_oe == $past(gpio_oe))
    else $error("one pulse did not end");

  chk_gpio_return: assert property (@(posedge clock) disable iff (rst)  // [R11]
    !enable_r |=> pin_out == $past(gpio_out) && pin_oe == $past(gpio_oe))
    else $error("pins not returned to gpio");

  chk_high_start: assert property (@(posedge clock) disable iff (rst)  // [R12]
    (live[0] && count_r == 16'h0000 && db_short_r == 8'h00 && trail_end != 16'h0000
     && db_long_r <= duty_r) |=> pin_out[0] == ~$past(inv_r[0]))
    else $error("cycle did not start high");

  chk_low_at_duty: assert property (@(posedge clock) disable iff (rst)  // [R13]
    (live[1] && count_r >= duty_r) |=> pin_out[1] == $past(inv_r[0]))
    else $error("output not low past duty");

  chk_period_lock: assert property (@(posedge clock) disable iff (rst)  // [R21]
    (stopped_r && wr_acc && address == OFS_PERIOD) |=> $stable(period_r))
    else $error("period changed while locked");

  chk_no_pulse: assert property (@(posedge clock) disable iff (rst)  // [R20]
    (live[2] && db_long_r > duty_r) |=> pin_out[2] == $past(inv_r[1]))
    else $error("pulse despite long dead band");

  chk_div_tick: assert property (@(posedge clock) disable iff (rst)  // [R8]
    (div_sel_r == 3'h6 && pre_r[0]) |-> tick ##1 !tick)
    else $error("divide by two tick wrong");

  cov_overflow: cover property (@(posedge clock) disable iff (rst) ovf_evt);
  cov_one_pulse: cover property (@(posedge clock) disable iff (rst)
    ovf_evt && one_pulse_r);
  cov_locked: cover property (@(posedge clock) disable iff (rst) $rose(stopped_r));
  cov_dead_band: cover property (@(posedge clock) disable iff (rst)
    live[0] && db_short_r != 8'h00 && wave);
  cov_inverted: cover property (@(posedge clock) disable iff (rst)
    live[2] && inv_r[1]);

endmodule

// ---- sim/fcpwm_load.sv ----
`timescale 1ns/10ps
module fcpwm_load (
  // Clock and count clear
  input  wire logic        clock,
  input  wire logic        clr,
  // Pins
  input  wire logic [3:0]  pin_out,
  input  wire logic [3:0]  pin_oe,
  // Counts per pin
  output logic [3:0][15:0] highs,
  output logic [3:0][15:0] rises
);
  // ----
  // Load sees a pin high only while driven
  // ----
  logic [3:0] last_r;

  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        highs[i] <= 16'h0;
        rises[i] <= 16'h0;
      end else begin
        if (pin_oe[i] & pin_out[i])
          highs[i] <= highs[i] + 16'h1;
        if (pin_oe[i] & pin_out[i] & ~last_r[i])
          rises[i] <= rises[i] + 16'h1;
      end
    end
    last_r <= pin_oe & pin_out;
  end
endmodule

// ---- sim/test_four_channel_pwm_with_one_pulse.sv ----
`timescale 1ns/10ps
module test_four_channel_pwm_with_one_pulse
  import fcpwm_pkg::*;
();
  logic             clock, rst, read, write, waitrequest, irq, wake, clr;
  logic [4:0]       address;
  logic [3:0]       byteenable, gpio_out, gpio_oe, pin_out, pin_oe;
  logic [31:0]      writedata, readdata, q;
  logic [3:0][15:0] highs, rises;
  int               fail_count, cmp_count, cyc, d;

  fcpwm_top DUT (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .wake(wake));

  fcpwm_load load (.clock(clock), .clr(clr), .pin_out(pin_out), .pin_oe(pin_oe),
    .highs(highs), .rises(rises));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----
  // Tasks
  // ----
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] dat);
    @(posedge clock);
    address   <= a;
    read      <= ~wr_en;
    write     <= wr_en;
    writedata <= dat;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_val(q, e);
  endtask

  task automatic pulse_clr();
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask

  // Configure, enable, then count over win cycles (after settling unless once)
  task automatic pwm(input logic [7:0] ctl, input logic [5:0] ch, input logic [15:0] per,
                     input logic [15:0] duty, input logic [7:0] sh, input logic [15:0] lg,
                     input int win, input logic once);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PERIOD, {16'h0, per});
    wr(OFS_DUTY, {16'h0, duty});
    wr(OFS_DBSHORT, {24'h0, sh});
    wr(OFS_DBLONG, {16'h0, lg});
    wr(OFS_CHAN, {26'h0, ch});
    pulse_clr();
    wr(OFS_CTRL, {24'h0, ctl});
    repeat (win) @(posedge clock);
    if (!once) begin
      pulse_clr();
      repeat (win) @(posedge clock);
    end
    #1;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc > 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ----
  // Tests
  // ----
  initial begin
    rst        = 1'b1;
    read       = 1'b0;
    write      = 1'b0;
    clr        = 1'b0;
    address    = 5'h00;
    writedata  = 32'h0;
    byteenable = 4'hf;
    gpio_out   = 4'ha;
    gpio_oe    = 4'h7;
    fail_count = 0;
    cmp_count  = 0;
    cyc        = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 8; i++)
      rdchk(5'(4 * i), 32'h0);
    wr(5'h02, 32'hffff);
    rdchk(5'h02, 32'h0);
    wr(OFS_PERIOD, 32'hbeef);
    rdchk(OFS_PERIOD, 32'hbeef);
    chk_val({24'h0, pin_oe, pin_out}, 32'h7a);
    gpio_oe <= 4'hf;
    for (int c = 0; c < 8; c++) begin
      d = 128 >> c;
      pwm(8'h80 | 8'(c << 4), 6'h03, 16'h4, 16'h2, 8'h0, 16'h0, 20 * d, 1'b0);
      chk_val({16'h0, highs[0]}, 32'(10 * d));
      chk_val({16'h0, rises[0]}, 32'h5);
    end
    pwm(8'hf4, 6'h11, 16'h4, 16'h1, 8'h0, 16'h0, 40, 1'b0);
    chk_val({16'h0, highs[0]}, 32'h1e);
    chk_val({16'h0, highs[2]}, 32'ha);
    chk_val({highs[3], highs[1]}, 32'h00280028);
    pwm(8'hf0, 6'h33, 16'h8, 16'h6, 8'h1, 16'h2, 80, 1'b0);
    chk_val({rises[0], highs[0]}, 32'h000a001e);
    chk_val({highs[3], highs[1]}, 32'h001e001e);
    pwm(8'hf8, 6'h33, 16'h8, 16'h6, 8'h1, 16'h7, 80, 1'b0);
    chk_val({highs[2], highs[0]}, 32'h00500000);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ, 32'h0);
    rdchk(OFS_IRQ, 32'h0);
    wr(OFS_IRQ, 32'h08);
    @(posedge clock);
    #1;
    chk_val({30'h0, irq, wake}, 32'h0);
    rdchk(OFS_IRQ, 32'h08);
    wr(OFS_IRQ, 32'h88);
    @(posedge clock);
    #1;
    chk_val({30'h0, irq, wake}, 32'h3);
    wr(OFS_IRQ, 32'h80);
    pwm(8'hf1, 6'h01, 16'h4, 16'h2, 8'h0, 16'h0, 40, 1'b1);
    chk_val({rises[0], highs[0]}, 32'h00010002);
    chk_val({24'h0, pin_oe, pin_out}, {24'h0, gpio_oe, gpio_out});
    rdchk(OFS_CTRL, 32'h71);
    rdchk(OFS_IRQ, 32'h88);
    gpio_out <= 4'hb;
    pwm(8'hf0, 6'h01, 16'h0, 16'h0, 8'h0, 16'h0, 20, 1'b1);
    chk_val({16'h0, highs[0]}, 32'h17);
    wr(OFS_PERIOD, 32'h4);
    rdchk(OFS_PERIOD, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PERIOD, 32'h4);
    rdchk(OFS_PERIOD, 32'h4);
    wrap_up();
  end
endmodule
